// [logic/sdc_pkg.sv]
// Constants shared by the strobe delay and control block.
// Assumes one core clock that serves as edge and system clock.
package sdc_pkg;
    localparam int DLY_W = 9;          // Delay setting width from the master loop
    localparam int PTR_W = 3;          // Input FIFO pointer width
    localparam int FIFO_DEPTH = 8;     // Entries before a pointer wraps
    localparam int READ_W = 2;         // Read indication width
    localparam int SEL_W = 3;          // Read pulse selection width
    localparam int GROUP_PINS = 16;    // Pins in one strobe group
    localparam int STROBE_PINS = 2;    // Fixed pins of the differential strobe
    localparam int DATA_PINS = GROUP_PINS - STROBE_PINS;
    localparam int TAP_DEPTH = 16;     // Taps of the modelled strobe delay line
    localparam int TAP_W = 4;
    localparam int QUARTER_SHIFT = 2;  // One quarter of the loop code is 90 degrees
    localparam int FULL_SHIFT = 0;
    localparam int PHASE_W = 2;        // Four write phases per period
    localparam logic [PHASE_W-1:0] PHASE_90 = 2'h1;
    localparam logic [PTR_W-1:0] PTR_RST = 3'h0;
    localparam logic [PTR_W-1:0] PTR_ONE = 3'h1;
    localparam logic [DLY_W-1:0] DLY_RST = 9'h000;
    localparam logic [DLY_W-1:0] DLY_ONE = 9'h001;
    localparam logic [DLY_W-1:0] DLY_MAX = 9'h1ff;
    localparam int CLK_PERIOD_NS = 10;

    // One-hot read framing states
    typedef enum logic [2:0] {
        SDC_IDLE = 3'h1,
        SDC_BURST = 3'h2,
        SDC_DRAIN = 3'h4
    } sdc_state_t;
endpackage

// [logic/sdc_dly_if.sv]
// Carrier between the top and its delay adjustment units.
// Assumes all members are driven on core_clk.
`timescale 1ns/1ps
interface sdc_dly_if;
    logic load_n;
    logic step;
    logic dir;
    logic [sdc_pkg::DLY_W-1:0] base;
    logic [sdc_pkg::DLY_W-1:0] setting;
    logic cout;

    modport ctrl (input load_n, input step, input dir, input base, output setting, output cout);
    modport user (output load_n, output step, output dir, output base, input setting, input cout);
endinterface

// [logic/sdc_sync.sv]
// Two-flop level synchroniser, parameterised width.
// Assumes each bit is a level or a gray-coded word.
`timescale 1ns/1ps
module sdc_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_q;

    // First stage feeds only the second; no reset so the chain settles freely
    always_ff @(posedge clk) begin
        meta_q <= d;
        q <= meta_q;
    end
endmodule

// [logic/sdc_dly_step.sv]
// One margin-adjustable slave delay setting.
// Assumes load, step and direction come from core_clk logic.
`timescale 1ns/1ps
module sdc_dly_step #(
    parameter int SHIFT = 0
) (
    input wire logic core_clk,
    input wire logic rstn,
    sdc_dly_if.ctrl dl
);
    logic [sdc_pkg::DLY_W-1:0] offs_q;
    logic step_q;
    logic cout_q;
    logic [sdc_pkg::DLY_W-1:0] scaled;
    logic [sdc_pkg::DLY_W:0] sum;
    logic step_rise;
    logic at_top;
    logic at_bot;

    // Slave setting follows the master code, scaled, plus the core offset
    assign scaled = dl.base >> SHIFT;
    assign sum = {1'b0, scaled} + {1'b0, offs_q};
    assign dl.setting = sum[sdc_pkg::DLY_W] ? sdc_pkg::DLY_MAX : sum[sdc_pkg::DLY_W-1:0];
    assign dl.cout = cout_q;
    assign step_rise = dl.step & ~step_q;
    assign at_top = (dl.setting == sdc_pkg::DLY_MAX);
    assign at_bot = (offs_q == sdc_pkg::DLY_RST);

    // One tap per rising step; clamp rather than wrap, flag the clamp
    always_ff @(posedge core_clk) begin
        if (!rstn || !dl.load_n) begin
            offs_q <= sdc_pkg::DLY_RST;
            cout_q <= 1'b0;
        end else if (step_rise) begin
            if (!dl.dir && !at_top) begin
                offs_q <= offs_q + sdc_pkg::DLY_ONE;
            end else if (dl.dir && !at_bot) begin
                offs_q <= offs_q - sdc_pkg::DLY_ONE;
            end
            cout_q <= dl.dir ? at_bot : at_top;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            step_q <= 1'b0;
        end else begin
            step_q <= dl.step;
        end
    end
endmodule

// [logic/sdc_top.sv]
// Strobe delay and control for one strobe group of a DDR interface.
// Assumes core_clk is the edge clock, equal in rate to the memory clock,
// and strobe_clk is the delayed strobe, which may stop between bursts.
// How it works
// R01: Read strobe delayed by loop-governed slave setting
// R02: Read capture strobe lags incoming strobe 90 degrees
// R03: Write strobe and data clocks, 90 apart
// R04: Leveling delay adjusted by load, direction, step
// R05: Read and write delays take core margin steps
// R06: Three-bit read and write FIFO pointers
// R07: Data valid and burst detect to controller
// R08: Controller gives read indication and pulse select
// R09: Edge clock equals memory clock rate
// R10: SDR tristate: one flop drives buffer enable
// R11: DDR tristate: two bits, both clocks, memory side
// R12: Sixteen pins a group, two for strobe
// R13: Dynamic input termination for DDR reads
// R14: Write side on strobe, read side on edge
// R15: Pointers step, wrap at eight, reset zero
`timescale 1ns/1ps
module sdc_top #(
    parameter bit MEM_SIDE = 1'b1,
    parameter int GROUP_PINS = sdc_pkg::GROUP_PINS
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic strobe_clk,
    input wire logic strobe_in,
    input wire logic [sdc_pkg::READ_W-1:0] read_request,
    input wire logic [sdc_pkg::SEL_W-1:0] read_pulse_select,
    input wire logic [sdc_pkg::DLY_W-1:0] delay_setting_in,
    input wire logic read_delay_load_n,
    input wire logic read_delay_step,
    input wire logic read_delay_dir,
    input wire logic write_delay_load_n,
    input wire logic write_delay_step,
    input wire logic write_delay_dir,
    input wire logic level_delay_load_n,
    input wire logic level_delay_step,
    input wire logic level_delay_dir,
    input wire logic tristate_ctrl_in,
    input wire logic [1:0] tristate_ddr_in,
    input wire logic ddr_mode,
    input wire logic term_enable,
    output logic read_capture_strobe,
    output logic strobe_write_clock,
    output logic data_write_clock,
    output logic [sdc_pkg::PTR_W-1:0] fifo_read_pointer,
    output logic [sdc_pkg::PTR_W-1:0] fifo_write_pointer,
    output logic read_data_valid,
    output logic burst_detect,
    output logic read_delay_count,
    output logic write_delay_count,
    output logic [sdc_pkg::DLY_W-1:0] delay_setting_out,
    output logic tristate_ctrl_out,
    output logic term_on
);
    // Group shape; the data pin count is derived here but nothing downstream uses it
    localparam int DATA_PINS = GROUP_PINS - sdc_pkg::STROBE_PINS; // see R12

    sdc_dly_if rd_if ();
    sdc_dly_if wr_if ();
    sdc_dly_if lv_if ();

    // Read side slave: quarter of the master code plus margin  see R01 see R02
    assign rd_if.base = delay_setting_in;
    assign rd_if.load_n = read_delay_load_n; // see R05
    assign rd_if.step = read_delay_step;
    assign rd_if.dir = read_delay_dir;
    assign wr_if.base = delay_setting_in;
    assign wr_if.load_n = write_delay_load_n; // see R05
    assign wr_if.step = write_delay_step;
    assign wr_if.dir = write_delay_dir;
    assign lv_if.base = delay_setting_in;
    assign lv_if.load_n = level_delay_load_n; // see R04
    assign lv_if.step = level_delay_step;
    assign lv_if.dir = level_delay_dir;

    sdc_dly_step #(.SHIFT(sdc_pkg::QUARTER_SHIFT)) u_rd (
        .core_clk(core_clk), .rstn(rstn), .dl(rd_if.ctrl));
    sdc_dly_step #(.SHIFT(sdc_pkg::QUARTER_SHIFT)) u_wr (
        .core_clk(core_clk), .rstn(rstn), .dl(wr_if.ctrl));
    sdc_dly_step #(.SHIFT(sdc_pkg::FULL_SHIFT)) u_lv (
        .core_clk(core_clk), .rstn(rstn), .dl(lv_if.ctrl));

    // Strobe pin sampled twice before the delay model reads it
    logic strobe_meta_q;
    logic strobe_sync_q;
    logic [sdc_pkg::TAP_DEPTH-1:0] taps_q;
    logic [sdc_pkg::TAP_W-1:0] tap_sel;
    logic rd_cap_q;

    assign tap_sel = rd_if.setting[sdc_pkg::TAP_W-1:0]; // see R01

    always_ff @(posedge core_clk) begin
        strobe_meta_q <= strobe_in;
        strobe_sync_q <= strobe_meta_q;
    end

    // Delay line model: tapped shift of the sampled strobe  see R02
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            taps_q <= '0;
            rd_cap_q <= 1'b0;
        end else begin
            taps_q <= {taps_q[sdc_pkg::TAP_DEPTH-2:0], strobe_sync_q};
            rd_cap_q <= taps_q[tap_sel];
        end
    end

    // Write phases: level offset shifts both; data leads strobe by 90
    logic [sdc_pkg::PHASE_W-1:0] ph_cnt_q;
    logic [sdc_pkg::PHASE_W-1:0] ph_strobe;
    logic [sdc_pkg::PHASE_W-1:0] ph_data;
    logic sw_q;
    logic dw_q;

    assign ph_strobe = ph_cnt_q + lv_if.setting[sdc_pkg::PHASE_W-1:0] // see R04
                       + wr_if.setting[sdc_pkg::PHASE_W-1:0];
    assign ph_data = ph_strobe + sdc_pkg::PHASE_90; // see R03

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            ph_cnt_q <= '0;
            sw_q <= 1'b0;
            dw_q <= 1'b0;
        end else begin
            ph_cnt_q <= ph_cnt_q + 2'h1;
            sw_q <= ph_strobe[sdc_pkg::PHASE_W-1]; // see R03
            dw_q <= ph_data[sdc_pkg::PHASE_W-1];
        end
    end

    // Read framing: delayed read indication picks the window  see R08
    sdc_pkg::sdc_state_t st_q;
    sdc_pkg::sdc_state_t st_d;
    logic [(1 << sdc_pkg::SEL_W)-1:0] rd_hist_q;
    logic rd_pulse;
    logic fifo_empty;
    logic window;

    assign rd_pulse = rd_hist_q[read_pulse_select];
    assign window = (st_q == sdc_pkg::SDC_BURST);

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            rd_hist_q <= '0;
        end else begin
            rd_hist_q <= {rd_hist_q[(1 << sdc_pkg::SEL_W)-2:0], |read_request};
        end
    end

    // Stay open while pulses last, then drain what the strobe wrote
    always_comb begin
        st_d = st_q;
        case (st_q)
            sdc_pkg::SDC_IDLE: begin
                if (rd_pulse) begin
                    st_d = sdc_pkg::SDC_BURST;
                end
            end
            sdc_pkg::SDC_BURST: begin
                if (!rd_pulse) begin
                    st_d = sdc_pkg::SDC_DRAIN;
                end
            end
            sdc_pkg::SDC_DRAIN: begin
                if (rd_pulse) begin
                    st_d = sdc_pkg::SDC_BURST;
                end else if (fifo_empty) begin
                    st_d = sdc_pkg::SDC_IDLE;
                end
            end
            default: begin
                st_d = sdc_pkg::SDC_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            st_q <= sdc_pkg::SDC_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    // Reset and window cross into the strobe domain as levels
    logic [1:0] to_strobe;
    logic srst_n_s;
    logic win_s;

    sdc_sync #(.W(2)) u_to_strobe (
        .clk(strobe_clk),
        .d({rstn, window}),
        .q(to_strobe)
    );
    assign srst_n_s = to_strobe[1];
    assign win_s = to_strobe[0];

    // Write pointer lives on the delayed strobe; gray copy for crossing
    // Reset here needs strobe edges; the strobe may be idle at reset time
    logic [sdc_pkg::PTR_W-1:0] wptr_q;
    logic [sdc_pkg::PTR_W-1:0] wgray_q;
    logic [sdc_pkg::PTR_W-1:0] wptr_nx;

    assign wptr_nx = wptr_q + sdc_pkg::PTR_ONE;

    always_ff @(posedge strobe_clk) begin
        if (!srst_n_s) begin
            wptr_q <= sdc_pkg::PTR_RST; // see R15
            wgray_q <= sdc_pkg::PTR_RST;
        end else if (win_s) begin
            wptr_q <= wptr_nx; // see R14 see R06
            wgray_q <= wptr_nx ^ (wptr_nx >> 1);
        end
    end

    // Gray pointer into the edge domain, back to binary
    logic [sdc_pkg::PTR_W-1:0] wgray_e;
    logic [sdc_pkg::PTR_W-1:0] wbin_e;

    sdc_sync #(.W(sdc_pkg::PTR_W)) u_to_edge (
        .clk(core_clk),
        .d(wgray_q),
        .q(wgray_e)
    );
    assign wbin_e = {wgray_e[2], wgray_e[2] ^ wgray_e[1], wgray_e[2] ^ wgray_e[1] ^ wgray_e[0]};

    // Read pointer on the edge clock, one step per unread entry
    logic [sdc_pkg::PTR_W-1:0] rptr_q;
    logic valid_q;
    logic burst_q;
    logic [sdc_pkg::PTR_W-1:0] wbin_prev_q;

    assign fifo_empty = (rptr_q == wbin_e);

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            rptr_q <= sdc_pkg::PTR_RST; // see R15
            valid_q <= 1'b0;
            burst_q <= 1'b0;
            wbin_prev_q <= sdc_pkg::PTR_RST;
        end else begin
            if (!fifo_empty) begin
                rptr_q <= rptr_q + sdc_pkg::PTR_ONE; // see R14 see R06
            end
            valid_q <= !fifo_empty; // see R07
            burst_q <= (st_q != sdc_pkg::SDC_IDLE) && (wbin_e != wbin_prev_q);
            wbin_prev_q <= wbin_e;
        end
    end

    // Tristate: SDR flop or DDR pair picked by write phase  see R10 see R11
    logic [1:0] tri_sys_q;
    logic tri_q;
    logic ddr_ok;

    assign ddr_ok = MEM_SIDE && ddr_mode;

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            tri_sys_q <= 2'h0;
            tri_q <= 1'b0;
        end else begin
            tri_sys_q <= tristate_ddr_in;
            tri_q <= ddr_ok ? tri_sys_q[ph_cnt_q[0]] : tristate_ctrl_in;
        end
    end

    // Output registers; termination on only while reads are framed
    logic [sdc_pkg::DLY_W-1:0] dly_out_q;
    logic term_q;
    logic read_delay_count_q;
    logic write_delay_count_q;

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            dly_out_q <= sdc_pkg::DLY_RST;
            term_q <= 1'b0;
            read_delay_count_q <= 1'b0;
            write_delay_count_q <= 1'b0;
        end else begin
            dly_out_q <= rd_if.setting;
            term_q <= term_enable && (st_q != sdc_pkg::SDC_IDLE); // see R13
            read_delay_count_q <= rd_if.cout;
            write_delay_count_q <= wr_if.cout;
        end
    end

    assign read_capture_strobe = rd_cap_q;
    assign strobe_write_clock = sw_q;
    assign data_write_clock = dw_q;
    assign fifo_read_pointer = rptr_q;
    assign fifo_write_pointer = wptr_q;
    assign read_data_valid = valid_q;
    assign burst_detect = burst_q;
    assign read_delay_count = read_delay_count_q;
    assign write_delay_count = write_delay_count_q;
    assign delay_setting_out = dly_out_q;
    assign tristate_ctrl_out = tri_q;
    assign term_on = term_q;

    // Checks
    sequence s_sel_pulse;
        (st_q == sdc_pkg::SDC_IDLE) && rd_pulse;
    endsequence

    property p_tri_sdr;
        @(posedge core_clk) disable iff (!rstn)
        rstn && !ddr_mode |=> tristate_ctrl_out == $past(tristate_ctrl_in);
    endproperty
    a_tri_sdr: assert property (p_tri_sdr) else $error("sdr tristate not registered"); // see R10

    property p_tri_ddr;
        @(posedge core_clk) disable iff (!rstn)
        ddr_mode ##1 ddr_mode |=> tristate_ctrl_out == $past(tri_sys_q[ph_cnt_q[0]]);
    endproperty
    a_tri_ddr: assert property (p_tri_ddr) else $error("ddr tristate bit wrong"); // see R11

    property p_rptr_step;
        @(posedge core_clk) disable iff (!rstn)
        $changed(fifo_read_pointer) |-> fifo_read_pointer == 3'($past(fifo_read_pointer) + 3'h1);
    endproperty
    a_rptr_step: assert property (p_rptr_step) else $error("read pointer jumped"); // see R15

    property p_wptr_step;
        @(posedge strobe_clk) disable iff (!srst_n_s)
        $changed(fifo_write_pointer) |-> fifo_write_pointer == 3'($past(fifo_write_pointer) + 3'h1);
    endproperty
    a_wptr_step: assert property (p_wptr_step) else $error("write pointer jumped"); // see R06

    property p_rptr_rst;
        @(posedge core_clk) disable iff (1'b0)
        !rstn |=> fifo_read_pointer == 3'h0 && !read_data_valid;
    endproperty
    a_rptr_rst: assert property (p_rptr_rst) else $error("read pointer not cleared"); // see R15

    property p_valid;
        @(posedge core_clk) disable iff (!rstn)
        !fifo_empty |=> read_data_valid ##1 (fifo_read_pointer != $past(fifo_read_pointer, 2));
    endproperty
    a_valid: assert property (p_valid) else $error("valid or pointer missing"); // see R07

    property p_quarter;
        @(posedge core_clk) disable iff (!rstn)
        !read_delay_load_n |=> rd_if.setting == (delay_setting_in >> sdc_pkg::QUARTER_SHIFT);
    endproperty
    a_quarter: assert property (p_quarter) else $error("read delay not quarter code"); // see R02

    property p_write_phase;
        @(posedge core_clk) disable iff (!rstn)
        $past(rstn) && $stable(lv_if.setting) && $stable(wr_if.setting)
            |=> strobe_write_clock == $past(data_write_clock);
    endproperty
    a_write_phase: assert property (p_write_phase) else $error("write clocks not 90 apart"); // see R03

    property p_frame;
        @(posedge core_clk) disable iff (!rstn)
        s_sel_pulse |=> (st_q == sdc_pkg::SDC_BURST) ##1 (term_on == $past(term_enable));
    endproperty
    a_frame: assert property (p_frame) else $error("read window or termination wrong"); // see R13
endmodule

// [test/sdc_mem_model.sv]
// Memory-side strobe source for the strobe delay bench.
// Assumes the bench calls burst() during reset or while a read window is open.
`timescale 1ns/1ps
module sdc_mem_model (
    output logic strobe_clk,
    output logic strobe_in
);
    // Strobe idles low between bursts, no free-running clock
    initial begin
        strobe_clk = 1'b0;
        strobe_in = 1'b0;
    end

    // Read strobe at 32 ns; odd start offset keeps it unrelated to core_clk
    task automatic burst(input int edges);
        #3.7;
        repeat (edges) begin
            strobe_clk = 1'b1;
            strobe_in = 1'b1;
            #16;
            strobe_clk = 1'b0;
            strobe_in = 1'b0;
            #16;
        end
    endtask
endmodule

// [test/test_sdc_top.sv]
// Self-checking bench for the strobe delay and control top.
// Assumes the memory model drives the strobe and this bench acts as controller.
`timescale 1ns/1ps
module test_sdc_top;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic strobe_clk, strobe_in;
    logic [1:0] read_request = 2'h0;
    logic [2:0] read_pulse_select = 3'h0;
    logic [8:0] delay_setting_in = 9'h000;
    logic [2:0] ld_n = 3'h7;
    logic [2:0] stp = 3'h0;
    logic [2:0] dir = 3'h0;
    logic tristate_ctrl_in = 1'b0;
    logic [1:0] tristate_ddr_in = 2'h0;
    logic ddr_mode = 1'b0;
    logic term_enable = 1'b1;
    logic read_capture_strobe, strobe_write_clock, data_write_clock;
    logic [2:0] fifo_read_pointer, fifo_write_pointer;
    logic read_data_valid, burst_detect, read_delay_count, write_delay_count;
    logic [8:0] delay_setting_out;
    logic tristate_ctrl_out, term_on;
    int num_errors = 0;
    int comparisons = 0;
    int wcount = 0;
    int rd_off = 0;
    logic [2:0] wprev = 3'h0;
    logic [2:0] rprev = 3'h0;
    int wq[$];
    logic seen_bd, seen_dv, seen_term, seen_rcs;

    // Edge clock; the partner model supplies the strobe
    always #5 core_clk = ~core_clk;

    sdc_mem_model sdc_mem_model_i (.strobe_clk, .strobe_in);

    sdc_top sdc_top_i (.core_clk, .rstn, .strobe_clk, .strobe_in, .read_request,
        .read_pulse_select, .delay_setting_in, .read_delay_load_n(ld_n[0]),
        .read_delay_step(stp[0]), .read_delay_dir(dir[0]), .write_delay_load_n(ld_n[1]),
        .write_delay_step(stp[1]), .write_delay_dir(dir[1]), .level_delay_load_n(ld_n[2]),
        .level_delay_step(stp[2]), .level_delay_dir(dir[2]), .tristate_ctrl_in,
        .tristate_ddr_in, .ddr_mode, .term_enable, .read_capture_strobe, .strobe_write_clock,
        .data_write_clock, .fifo_read_pointer, .fifo_write_pointer, .read_data_valid,
        .burst_detect, .read_delay_count, .write_delay_count, .delay_setting_out,
        .tristate_ctrl_out, .term_on);

    task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    function automatic int rd_exp();
        return int'(delay_setting_in >> 2) + rd_off;
    endfunction

    // Pointer model: each move is a single step, wrapping after eight;
    // a queue of written slots is popped by every read step
    always @(fifo_write_pointer) begin
        if (rstn === 1'b1) begin
            chk(9'(fifo_write_pointer), 9'(3'(wprev + 3'h1)));
            wq.push_back((int'(wprev) + 1) % 8);
            wcount++;
        end
        wprev = fifo_write_pointer;
    end

    always @(fifo_read_pointer) begin
        if (rstn === 1'b1) begin
            chk(9'(fifo_read_pointer), 9'(3'(rprev + 3'h1)));
            chk(9'(fifo_read_pointer), 9'(wq.size() > 0 ? wq.pop_front() : 9'h1ff));
        end
        rprev = fifo_read_pointer;
    end

    // Sticky flags, cleared by each burst
    always @(posedge core_clk) begin
        seen_bd |= (burst_detect === 1'b1);
        seen_dv |= (read_data_valid === 1'b1);
        seen_term |= (term_on === 1'b1);
        seen_rcs |= (read_capture_strobe === 1'b1);
    end

    // Strobe edges during reset are needed to clear the write side
    task automatic reset_dut();
        @(posedge core_clk);
        rstn <= 1'b0;
        sdc_mem_model_i.burst(4);
        tick(2);
        chk(9'(fifo_write_pointer), 9'h000);
        chk(9'(fifo_read_pointer), 9'h000);
        chk(9'(read_data_valid), 9'h000);
        chk(9'(tristate_ctrl_out), 9'h000);
        @(posedge core_clk);
        rstn <= 1'b1;
        wcount = 0;
        wq.delete();
        rd_off = 0;
    endtask

    task automatic load_all();
        @(posedge core_clk);
        ld_n <= 3'h0;
        @(posedge core_clk);
        ld_n <= 3'h7;
        tick(3);
        rd_off = 0;
        chk(delay_setting_out, 9'(rd_exp()));
    endtask

    // One margin step on line k; step must fall before the next one
    task automatic step(input int k, input logic down);
        @(posedge core_clk);
        dir[k] <= down;
        stp[k] <= 1'b1;
        @(posedge core_clk);
        stp[k] <= 1'b0;
        tick(3);
        if (k == 0) begin
            if (down && rd_off > 0) rd_off--;
            else if (!down && rd_exp() < 511) rd_off++;
            chk(delay_setting_out, 9'(rd_exp()));
        end
    endtask

    task automatic read_burst(input int sel);
        int n;
        n = 0;
        seen_bd = 1'b0;
        seen_dv = 1'b0;
        seen_term = 1'b0;
        seen_rcs = 1'b0;
        @(posedge core_clk);
        read_pulse_select <= 3'(sel);
        term_enable <= (sel != 3);
        read_request <= 2'($urandom_range(1, 3));
        repeat (sel + 4) @(posedge core_clk);
        sdc_mem_model_i.burst(6);
        @(posedge core_clk);
        read_request <= 2'h0;
        tick(12);
        // Bounded drain wait; a hang ends the run
        while ((read_data_valid !== 1'b0 || fifo_read_pointer !== fifo_write_pointer)
               && n < 50) begin
            tick(1);
            n++;
        end
        if (n == 50) begin
            num_errors++;
            wrap_up();
        end
        chk(9'(fifo_read_pointer), 9'(wcount % 8));
        chk(9'(wq.size()), 9'h000);
        chk(9'(seen_bd), 9'h001);
        chk(9'(seen_dv), 9'h001);
        chk(9'(seen_term), 9'(sel != 3));
        chk(9'(seen_rcs), 9'h001);
    endtask

    initial begin
        #200000;
        num_errors++;
        wrap_up();
    end

    initial begin
        logic w[12];
        logic d[12];
        logic pa, pb, v, prev;
        prev = 1'b0;
        void'($urandom(80978));
        reset_dut();
        delay_setting_in <= 9'h1ff;
        load_all();
        step(0, 1'b1);
        chk(9'(read_delay_count), 9'h001);
        repeat (384) step(0, 1'b0);
        chk(9'(read_delay_count), 9'h000);
        step(0, 1'b0);
        chk(9'(read_delay_count), 9'h001);
        step(1, 1'b1);
        chk(9'(write_delay_count), 9'h001);
        step(1, 1'b0);
        chk(9'(write_delay_count), 9'h000);
        load_all();
        repeat (6) step(2, 1'($urandom));
        // Quiet window: data clock runs one phase ahead of strobe clock
        for (int i = 0; i < 12; i++) begin
            tick(1);
            w[i] = strobe_write_clock;
            d[i] = data_write_clock;
        end
        for (int i = 0; i < 8; i++) begin
            chk(9'(d[i]), 9'(w[i + 1]));
            chk(9'(w[i]), 9'(w[i + 4]));
            chk(9'(w[i] ^ w[i + 2]), 9'h001);
        end
        // Single-rate tristate: one flop of delay
        for (int i = 0; i < 20; i++) begin
            v = 1'($urandom);
            @(posedge core_clk);
            tristate_ctrl_in <= v;
            #1;
            if (i > 0) chk(9'(tristate_ctrl_out), 9'(prev));
            prev = v;
        end
        // Double-rate tristate: equal pairs pass, unequal pairs alternate
        @(posedge core_clk);
        ddr_mode <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            @(posedge core_clk);
            tristate_ddr_in <= 2'(i);
            tick(4);
            pa = tristate_ctrl_out;
            tick(1);
            pb = tristate_ctrl_out;
            if (i == 0 || i == 3) chk(9'(pa), 9'(i[0]));
            else chk(9'(pa ^ pb), 9'h001);
        end
        @(posedge core_clk);
        ddr_mode <= 1'b0;
        for (int s = 0; s < 8; s++) read_burst(s);
        reset_dut();
        read_burst(2);
        wrap_up();
    end
endmodule
